// ===== logic/bai_pkg.sv
// constants for the adapter interrupt controller
// Overview of operation
// - all requests leave on one shared pin
// - byte 0x3C holds firmware routing level
// - seven sources merge onto the output: four normal, three error flags
// - control bit 7 shows output active
// - bit 5 gates errors, bit 6 others
// - control bits 2-0 pick cable line
// - command bit 5 sends transmitter interrupt
// - incoming transmitter interrupt shows remote bit 1
// - remote command bit 6 clears it
// - remote command bit 5 sends receiver interrupt
// - incoming receiver interrupt shows local bit 5
// - command bit 6 clears receiver interrupt
// - command bit 7 clears latched errors
// - flag remote bus error responses
// - flag transfers unfinished after 30 us
// - flag detected data errors
// - backplane levels 1-7 shown live in status
// - dma bit 2 enables done interrupt
// - clearing dma bit 1 acknowledges done
`default_nettype none
package bai_pkg;
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_LOCAL_CMD  = 8'h04;
  localparam logic [7:0] ADDR_LOCAL_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0C;
  localparam logic [7:0] ADDR_REMOTE_ST  = 8'h10;
  localparam logic [7:0] ADDR_REMOTE_CMD = 8'h14;
  localparam logic [7:0] ADDR_DMA_CMD    = 8'h18;
  localparam logic [7:0] ADDR_ROUTING    = 8'h3C;

  localparam int BIT_ACTIVE     = 7;
  localparam int BIT_NORMAL_EN  = 6;
  localparam int BIT_ERROR_EN   = 5;
  localparam int BIT_SEL_HI     = 2;
  localparam int BIT_SEND_XMIT  = 5;
  localparam int BIT_ACK_RECV   = 6;
  localparam int BIT_ACK_ERR    = 7;
  localparam int BIT_RECV_PEND  = 5;
  localparam int BIT_BUS_ERR    = 0;
  localparam int BIT_TIMEOUT    = 1;
  localparam int BIT_DATA_ERR   = 2;
  localparam int BIT_XMIT_PEND  = 1;
  localparam int BIT_SEND_RECV  = 5;
  localparam int BIT_ACK_XMIT   = 6;
  localparam int BIT_DMA_IRQ_EN = 2;
  localparam int BIT_DMA_DONE   = 1;

  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_ROUTING = 8'hFF;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  localparam int CLOCK_MHZ       = 25;
  localparam int TIMEOUT_US      = 30;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_US * CLOCK_MHZ;
  localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CYCLES - 1);

  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_BUSY
  } bai_xfer_type;
endpackage : bai_pkg
`default_nettype wire

// ===== logic/bai_irq_ctrl.sv
// interrupt merge, programmed interrupts and error flags of the adapter
`default_nettype none
module bai_irq_ctrl (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            intaOut,
  output logic            intaOeN,
  input  wire logic [7:1] cableIrqIn,
  output logic      [7:1] cableIrqOut,
  input  wire logic       xmitIrqIn,
  input  wire logic       xmitAckIn,
  output logic            recvIrqOut,
  input  wire logic       recvIrqIn,
  input  wire logic       xferStart,
  input  wire logic       xferDone,
  input  wire logic       xferBusErr,
  input  wire logic       xferDataErr,
  input  wire logic       dmaEnd
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = (a == want);
  endfunction : hit

  logic [7:0]             control;
  logic [7:0]             routing;
  logic                   xmitPend;
  logic                   xmitSent;
  logic                   recvPend;
  logic                   busErr;
  logic                   timeoutErr;
  logic                   dataErr;
  logic                   dmaIrqEn;
  logic                   dmaDone;
  logic [9:0]             waitCount;
  bai_pkg::bai_xfer_type  xferState;
  logic                   anyError;
  logic                   anyNormal;
  logic                   irqActive;
  logic                   timeoutHit;
  logic [7:0]             next_rdata;

  logic wrControl;
  logic wrLocalCmd;
  logic wrRemoteCmd;
  logic wrDmaCmd;
  logic wrRouting;

  assign wrControl   = regWrite && hit(regAddr, bai_pkg::ADDR_CONTROL);
  assign wrLocalCmd  = regWrite && hit(regAddr, bai_pkg::ADDR_LOCAL_CMD);
  assign wrRemoteCmd = regWrite && hit(regAddr, bai_pkg::ADDR_REMOTE_CMD);
  assign wrDmaCmd    = regWrite && hit(regAddr, bai_pkg::ADDR_DMA_CMD);
  assign wrRouting   = regWrite && hit(regAddr, bai_pkg::ADDR_ROUTING);

  ////////////////////////////////////////////////////////////////////////////
  // control byte; bit 7 is never stored, it reads the live output
  always_ff @(posedge clock) begin
    if (!resetn) begin
      control <= bai_pkg::RESET_CONTROL;
    end else if (wrControl) begin
      control <= {1'b0, regWdata[6:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      routing <= bai_pkg::RESET_ROUTING;
    end else if (wrRouting) begin
      routing <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outgoing transmitter interrupt, held until the far side takes it
  // select zero drops the send; holding it would fire later on a new line
  always_ff @(posedge clock) begin
    if (!resetn) begin
      xmitSent <= 1'b0;
    end else if (wrLocalCmd && regWdata[bai_pkg::BIT_SEND_XMIT] &&
                 control[bai_pkg::BIT_SEL_HI:0] != 3'h0) begin
      xmitSent <= 1'b1;
    end else if (xmitAckIn) begin
      xmitSent <= 1'b0;
    end
  end

  // select 000 sends nothing: no line matches code zero
  generate
    for (genvar i = 1; i <= 7; i++) begin : g_line
      assign cableIrqOut[i] = xmitSent &&
        (control[bai_pkg::BIT_SEL_HI:0] == 3'(i));
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!resetn) begin
      recvIrqOut <= 1'b0;
    end else begin
      recvIrqOut <= wrRemoteCmd && regWdata[bai_pkg::BIT_SEND_RECV];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // incoming programmed interrupts; a new arrival beats a same-cycle ack
  always_ff @(posedge clock) begin
    if (!resetn) begin
      xmitPend <= 1'b0;
    end else if (xmitIrqIn) begin
      xmitPend <= 1'b1;
    end else if (wrRemoteCmd && regWdata[bai_pkg::BIT_ACK_XMIT]) begin
      xmitPend <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      recvPend <= 1'b0;
    end else if (recvIrqIn) begin
      recvPend <= 1'b1;
    end else if (wrLocalCmd && regWdata[bai_pkg::BIT_ACK_RECV]) begin
      recvPend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer watchdog; a late completion after timeout is ignored
  assign timeoutHit = (xferState == bai_pkg::XFER_BUSY) && !xferDone &&
                      (waitCount == bai_pkg::TIMEOUT_LAST);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      xferState <= bai_pkg::XFER_IDLE;
      waitCount <= 10'h000;
    end else begin
      case (xferState)
        bai_pkg::XFER_IDLE: begin
          waitCount <= 10'h000;
          if (xferStart) begin
            xferState <= bai_pkg::XFER_BUSY;
          end
        end
        bai_pkg::XFER_BUSY: begin
          waitCount <= waitCount + 10'h001;
          if (xferDone || timeoutHit) begin
            xferState <= bai_pkg::XFER_IDLE;
            waitCount <= 10'h000;
          end
        end
        default: begin
          xferState <= bai_pkg::XFER_IDLE;
          waitCount <= 10'h000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error flags are sticky; an error in the ack cycle survives
  logic ackErr;
  assign ackErr = wrLocalCmd && regWdata[bai_pkg::BIT_ACK_ERR];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      busErr <= 1'b0;
    end else if (xferBusErr) begin
      busErr <= 1'b1;
    end else if (ackErr) begin
      busErr <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      timeoutErr <= 1'b0;
    end else if (timeoutHit) begin
      timeoutErr <= 1'b1;
    end else if (ackErr) begin
      timeoutErr <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dataErr <= 1'b0;
    end else if (xferDataErr) begin
      dataErr <= 1'b1;
    end else if (ackErr) begin
      dataErr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma done; software clears it by writing the bit as zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dmaIrqEn <= 1'b0;
    end else if (wrDmaCmd) begin
      dmaIrqEn <= regWdata[bai_pkg::BIT_DMA_IRQ_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dmaDone <= 1'b0;
    end else if (dmaEnd) begin
      dmaDone <= 1'b1;
    end else if (wrDmaCmd && !regWdata[bai_pkg::BIT_DMA_DONE]) begin
      dmaDone <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // merge; no latch, so the pin drops as soon as all are acknowledged
  assign anyError  = busErr || timeoutErr || dataErr;
  assign anyNormal = (|cableIrqIn) || xmitPend || recvPend ||
                     (dmaIrqEn && dmaDone);
  assign irqActive = (control[bai_pkg::BIT_ERROR_EN] && anyError) ||
                     (control[bai_pkg::BIT_NORMAL_EN] && anyNormal);

  // open drain: only ever pulls low
  assign intaOut = 1'b0;
  assign intaOeN = !irqActive;

  ////////////////////////////////////////////////////////////////////////////
  // read data registered: one cycle after the read strobe
  always_comb begin
    next_rdata = bai_pkg::RESET_BYTE;
    case (regAddr)
      bai_pkg::ADDR_CONTROL: begin
        next_rdata = {irqActive, control[6:0]};
      end
      bai_pkg::ADDR_LOCAL_STAT: begin
        next_rdata[bai_pkg::BIT_RECV_PEND] = recvPend;
        next_rdata[bai_pkg::BIT_BUS_ERR]   = busErr;
        next_rdata[bai_pkg::BIT_TIMEOUT]   = timeoutErr;
        next_rdata[bai_pkg::BIT_DATA_ERR]  = dataErr;
      end
      bai_pkg::ADDR_IRQ_STAT: begin
        next_rdata = {cableIrqIn, 1'b0};
      end
      bai_pkg::ADDR_REMOTE_ST: begin
        next_rdata[bai_pkg::BIT_XMIT_PEND] = xmitPend;
      end
      bai_pkg::ADDR_DMA_CMD: begin
        next_rdata[bai_pkg::BIT_DMA_IRQ_EN] = dmaIrqEn;
        next_rdata[bai_pkg::BIT_DMA_DONE]   = dmaDone;
      end
      bai_pkg::ADDR_ROUTING: begin
        next_rdata = routing;
      end
      default: begin
        next_rdata = bai_pkg::RESET_BYTE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      regRdata <= bai_pkg::RESET_BYTE;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_PIN_FOLLOWS: assert property (
    intaOeN == !((control[5] && (busErr || timeoutErr || dataErr)) ||
                 (control[6] && ((|cableIrqIn) || xmitPend || recvPend ||
                                 (dmaIrqEn && dmaDone)))))
    else $error("interrupt pin disagrees with enabled sources");

  AST_ACTIVE_BIT: assert property (
    regRead && regAddr == bai_pkg::ADDR_CONTROL |=> regRdata[7] == !$past(intaOeN))
    else $error("active bit does not track the pin");

  AST_ERR_GATE: assert property (
    !control[5] && !anyNormal |-> intaOeN)
    else $error("error raised pin while disabled");

  AST_LINE_SEL: assert property (
    control[2:0] == 3'h0 |-> cableIrqOut == 7'h00)
    else $error("cable line driven with select zero");

  AST_XMIT_SEND: assert property (
    wrLocalCmd && regWdata[5] && !xmitAckIn && !wrControl
    |=> cableIrqOut[control[2:0]] || control[2:0] == 3'h0)
    else $error("transmitter interrupt not sent");

  AST_XMIT_ACK: assert property (
    xmitPend && wrRemoteCmd && regWdata[6] && !xmitIrqIn |=> !xmitPend)
    else $error("transmitter interrupt not cleared");

  AST_RECV_SEND: assert property (
    wrRemoteCmd && regWdata[5] |=> recvIrqOut ##1
    (!recvIrqOut || $past(wrRemoteCmd && regWdata[bai_pkg::BIT_SEND_RECV])))
    else $error("receiver interrupt pulse wrong");

  AST_RECV_SET: assert property (
    recvIrqIn |=> recvPend)
    else $error("receiver interrupt lost");

  AST_ERR_ACK: assert property (
    ackErr && !xferBusErr && !xferDataErr && !timeoutHit |=> !anyError)
    else $error("errors not cleared");

  // checker count of cycles since a start with no completion seen
  logic [9:0] quietCount;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      quietCount <= 10'h000;
    end else if (xferState == bai_pkg::XFER_IDLE && xferStart) begin
      quietCount <= 10'h001;
    end else if (xferDone) begin
      quietCount <= 10'h000;
    end else if (quietCount != 10'h000 && quietCount != 10'h3FF) begin
      quietCount <= quietCount + 10'h001;
    end
  end

  AST_TIMEOUT: assert property (
    quietCount == 10'(bai_pkg::TIMEOUT_CYCLES) && !xferDone |=> timeoutErr)
    else $error("timeout not flagged on time");

  AST_DMA_ACK: assert property (
    wrDmaCmd && !regWdata[1] && !dmaEnd |=> !dmaDone)
    else $error("dma done not cleared");

  COV_BACKPLANE: cover property (cableIrqIn != 7'h00 && !intaOeN);
  COV_TIMEOUT:   cover property ($rose(timeoutErr));
  COV_DMA:       cover property (dmaDone && dmaIrqEn && !intaOeN);
  COV_CABLE_ACK: cover property (xmitSent && xmitAckIn);
  COV_RECV:      cover property (recvPend && !intaOeN);

endmodule : bai_irq_ctrl
`default_nettype wire

// ===== sim/bai_vme_model.sv
// far-side adapter model: backplane levels, programmed interrupts, cable acks
`default_nettype none
module bai_vme_model #(
  parameter int ACK_DELAY = 6
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:1] bpLevels,
  input  wire logic       fireXmit,
  input  wire logic       fireRecv,
  input  wire logic [7:1] cableIrqOut,
  input  wire logic       recvIrqOut,
  output logic      [7:1] cableIrqIn,
  output logic            xmitIrqIn,
  output logic            recvIrqIn,
  output logic            xmitAckIn,
  output var int          recvSeen
);
  logic [3:0] waitCount;
  ////////////////////////////////////////
  assign cableIrqIn = bpLevels;
  always_ff @(posedge clock) begin
    xmitIrqIn <= resetn & fireXmit;
    recvIrqIn <= resetn & fireRecv;
  end
  // slow ack: line held several cycles before the far side answers
  always_ff @(posedge clock) begin
    if (!resetn || cableIrqOut == 7'h00) begin
      waitCount <= 4'h0;
    end else if (waitCount != 4'hf) begin
      waitCount <= waitCount + 4'h1;
    end
  end
  assign xmitAckIn = (waitCount == 4'(ACK_DELAY));
  // receiver interrupt needs no answer over the cable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      recvSeen <= 0;
    end else if (recvIrqOut) begin
      recvSeen <= recvSeen + 1;
    end
  end
endmodule : bai_vme_model
`default_nettype wire

// ===== sim/tb_bai_irq_ctrl.sv
// self-checking bench for the adapter interrupt controller
`default_nettype none
module tb_bai_irq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock    = 1'b0;
  logic       resetn   = 1'b0;
  logic       regWrite = 1'b0;
  logic       regRead  = 1'b0;
  logic [7:0] regAddr  = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:1] bpLevels = 7'h00;
  logic [6:0] ev       = 7'h00; // start done buserr dataerr dma xmit recv
  logic [7:0] regRdata;
  logic [7:1] cableIrqIn, cableIrqOut;
  logic       intaOut, intaOeN, recvIrqOut, xmitIrqIn, recvIrqIn, xmitAckIn;
  int         recvSeen;
  int         n_errors = 0;
  int         checks   = 0;
  always #20 clock = ~clock;
  ////////////////////////////////////////
  bai_irq_ctrl bai_irq_ctrl_inst (.clock(clock), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .intaOut(intaOut), .intaOeN(intaOeN), .cableIrqIn(cableIrqIn),
    .cableIrqOut(cableIrqOut), .xmitIrqIn(xmitIrqIn), .xmitAckIn(xmitAckIn),
    .recvIrqOut(recvIrqOut), .recvIrqIn(recvIrqIn), .xferStart(ev[0]), .xferDone(ev[1]),
    .xferBusErr(ev[2]), .xferDataErr(ev[3]), .dmaEnd(ev[4]));
  bai_vme_model bai_vme_model_inst (.clock(clock), .resetn(resetn), .bpLevels(bpLevels),
    .fireXmit(ev[5]), .fireRecv(ev[6]), .cableIrqOut(cableIrqOut), .recvIrqOut(recvIrqOut),
    .cableIrqIn(cableIrqIn), .xmitIrqIn(xmitIrqIn), .recvIrqIn(recvIrqIn),
    .xmitAckIn(xmitAckIn), .recvSeen(recvSeen));
  ////////////////////////////////////////
  task automatic summarize;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(regRdata, exp, what);
  endtask : rd
  task automatic pin(input logic exp, input string what);
    @(posedge clock);
    @(negedge clock);
    chk({6'h00, intaOut, intaOeN}, {7'h00, exp}, what);
  endtask : pin
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask : pulse
  ////////////////////////////////////////
  task automatic t_reset;
    rd(8'h00, 8'h00, "control reset");
    rd(8'h3C, 8'hFF, "routing reset");
    wr(8'h3C, 8'h5A);
    rd(8'h3C, 8'h5A, "routing rw");
    wr(8'h20, 8'h77);
    rd(8'h20, 8'h00, "unmapped");
    pin(1'b1, "idle pin");
  endtask : t_reset
  task automatic t_recv;
    wr(8'h00, 8'h40);
    pulse(6);
    pin(1'b0, "recv pin");
    rd(8'h08, 8'h20, "recv pending");
    rd(8'h00, 8'hC0, "active bit");
    wr(8'h04, 8'h40);
    pin(1'b1, "recv ack pin");
    rd(8'h08, 8'h00, "recv ack");
    wr(8'h00, 8'h20);
    pulse(6);
    pin(1'b1, "recv masked");
    wr(8'h04, 8'h40);
  endtask : t_recv
  task automatic t_err;
    wr(8'h00, 8'h40);
    pulse(2);
    pin(1'b1, "err masked");
    rd(8'h08, 8'h01, "bus err");
    wr(8'h00, 8'h20);
    pin(1'b0, "err pin");
    pulse(3);
    rd(8'h08, 8'h05, "data err");
    wr(8'h04, 8'h80);
    rd(8'h08, 8'h00, "err ack");
    pin(1'b1, "err ack pin");
  endtask : t_err
  task automatic t_timeout;
    pulse(0);
    repeat (748) @(posedge clock);
    rd(8'h08, 8'h00, "no early timeout");
    chk({7'h00, intaOeN}, 8'h00, "timeout on time");
    repeat (8) @(posedge clock);
    rd(8'h08, 8'h02, "timeout");
    pin(1'b0, "timeout pin");
    wr(8'h04, 8'h80);
    pulse(0);
    repeat (5) @(posedge clock);
    pulse(1);
    repeat (800) @(posedge clock);
    rd(8'h08, 8'h00, "done in time");
  endtask : t_timeout
  task automatic t_cable;
    logic [7:0] exp;
    bpLevels <= 7'h00;
    for (int s = 0; s < 8; s++) begin
      exp = (s == 0) ? 8'h00 : 8'h01 << (s - 1);
      wr(8'h00, 8'(s));
      @(negedge clock);
      chk({1'b0, cableIrqOut}, 8'h00, "no stale send");
      wr(8'h04, 8'h20);
      @(posedge clock);
      @(negedge clock);
      chk({1'b0, cableIrqOut}, exp, "cable line");
      repeat (12) @(posedge clock);
      @(negedge clock);
      chk({1'b0, cableIrqOut}, 8'h00, "cable acked");
    end
  endtask : t_cable
  task automatic t_remote;
    int n;
    wr(8'h00, 8'h40);
    pulse(5);
    rd(8'h10, 8'h02, "xmit pending");
    pin(1'b0, "xmit pin");
    wr(8'h14, 8'h40);
    rd(8'h10, 8'h00, "xmit ack");
    pin(1'b1, "xmit ack pin");
    n = recvSeen;
    wr(8'h14, 8'h20);
    repeat (3) @(posedge clock);
    chk(8'(recvSeen - n), 8'h01, "recv sent");
  endtask : t_remote
  task automatic t_backplane;
    @(posedge clock);
    bpLevels <= 7'h48;
    pin(1'b0, "backplane pin");
    rd(8'h0C, 8'h90, "levels");
    wr(8'h00, 8'h00);
    pin(1'b1, "backplane masked");
    @(posedge clock);
    bpLevels <= 7'h00;
  endtask : t_backplane
  task automatic t_dma;
    wr(8'h00, 8'h40);
    pulse(4);
    pin(1'b1, "dma not enabled");
    rd(8'h18, 8'h02, "dma done unenabled");
    wr(8'h18, 8'h04);
    rd(8'h18, 8'h04, "dma done cleared");
    pulse(4);
    pin(1'b0, "dma pin");
    rd(8'h18, 8'h06, "dma done");
    wr(8'h18, 8'h06);
    rd(8'h18, 8'h06, "dma write one");
    wr(8'h18, 8'h04);
    rd(8'h18, 8'h04, "dma ack");
    pin(1'b1, "dma ack pin");
  endtask : t_dma
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_recv();
    t_err();
    t_timeout();
    t_cable();
    t_remote();
    t_backplane();
    t_dma();
    summarize();
  end
  // run needs about 1800 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : tb_bai_irq_ctrl
`default_nettype wire
